//--- core/ihsa_pkg.sv
// shared constants and types for the high-speed / alert-response two-wire link
package ihsa_pkg;
  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40; // 25 MHz system clock
  localparam int FS_SCL_PERIOD_NS = 2500; // 400 kHz bus clock
  localparam int HS_SCL_PERIOD_NS = 400; // 2.5 MHz bus clock
  // quarter of a bus clock period, least time, rounded up
  localparam int FS_QTR_CYC = (FS_SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HS_QTR_CYC = (HS_SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] FS_QTR_LAST = 5'(FS_QTR_CYC - 1);
  localparam logic [4:0] HS_QTR_LAST = 5'(HS_QTR_CYC - 1);
  // input filter: samples a line must hold before it is believed
  localparam logic [1:0] FS_FILT_LAST = 2'h2; // three samples
  localparam logic [1:0] HS_FILT_LAST = 2'h0; // one sample
  // -----------------------------------------------------------------
  // codes
  // -----------------------------------------------------------------
  localparam logic [4:0] HS_CODE_PFX = 5'h01; // master code 00001xxx
  localparam logic [6:0] ALERT_RESP_ADDR = 7'h0C; // 0001 100
  localparam logic [3:0] LAST_BIT = 4'h8; // ninth bit of a byte frame

  typedef enum logic [4:0] {
    IHSA_CMD_HS = 5'b00001, // send master code, stay on the bus
    IHSA_CMD_WR = 5'b00010, // address + one data byte
    IHSA_CMD_RD = 5'b00100, // address + one byte read
    IHSA_CMD_ARA = 5'b01000, // alert response read
    IHSA_CMD_STOP = 5'b10000 // release a held bus
  } ihsa_cmd_t;
endpackage : ihsa_pkg

//--- core/ihsa_if.sv
// open-drain two-wire bus plus alert line joining controller and device
`timescale 1ns/1ps
`default_nettype none
interface ihsa_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic s_alert_o;
  logic s_alert_oe;
  logic scl;
  logic sda;
  logic alert_n;

  // wired-and with pull-ups: a line is low while any enable is high
  assign scl = ~m_scl_oe;
  assign sda = ~(m_sda_oe | s_sda_oe);
  assign alert_n = ~s_alert_oe;

  modport dev (input scl, sda, alert_n, output s_sda_o, s_sda_oe, s_alert_o, s_alert_oe);
  modport ctl (input scl, sda, alert_n, output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe);
endinterface : ihsa_if
`default_nettype wire

//--- core/ihsa_dev.sv
// device end: slave with high-speed entry and alert response
`timescale 1ns/1ps
`default_nettype none
module ihsa_dev import ihsa_pkg::*; (
  input wire logic clock, // system clock
  input wire logic reset_n, // synchronous reset
  ihsa_if.dev bus, // two-wire bus
  input wire logic [6:0] own_addr, // own slave address
  input wire logic alert_req, // interrupt pending, drives alert
  input wire logic [7:0] tx_byte, // byte returned on reads
  output logic hs_mode, // high-speed filtering active
  output logic [7:0] rx_data, // last written byte
  output logic rx_valid, // pulse with rx_data
  output logic ara_won // pulse: own address sent in full
);
  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_ADDR = 7'b0000010,
    ST_ACK = 7'b0000100,
    ST_RX = 7'b0001000,
    ST_TX = 7'b0010000,
    ST_TXACK = 7'b0100000,
    ST_WAIT = 7'b1000000
  } ihsa_dst_t;

  ihsa_dst_t state_ff;
  logic [3:0] cnt_ff;
  logic [7:0] sh_ff;
  logic [7:0] tx_ff;
  logic rw_ff;
  logic ara_ff;
  logic mack_ff;
  logic sda_oe_ff;
  logic alert_oe_ff;
  logic hs_ff;
  logic [7:0] rx_data_ff;
  logic rx_valid_ff;
  logic ara_won_ff;
  logic [1:0] s1_ff;
  logic [1:0] s2_ff;
  logic [1:0] fd_ff;
  wire [1:0] filt;
  logic [1:0] filt_last;

  // -----------------------------------------------------------------
  // input synchronisers and spike filters, bit 1 scl, bit 0 sda
  // -----------------------------------------------------------------
  always_comb begin
    filt_last = hs_ff ? HS_FILT_LAST : FS_FILT_LAST;
  end

  // two-flop synchroniser for both lines
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      s1_ff <= 2'h3;
      s2_ff <= 2'h3;
    end else begin
      s1_ff <= {bus.scl, bus.sda};
      s2_ff <= s1_ff;
    end
  end

  generate
    for (genvar i = 0; i < 2; i++) begin : g_filt
      logic [1:0] run_ff;
      logic lvl_ff;
      // accept a new level once it has held for the filter length
      always_ff @(posedge clock) begin
        if (!reset_n) begin
          run_ff <= 2'h0;
          lvl_ff <= 1'b1;
        end else if (s2_ff[i] == lvl_ff) begin
          run_ff <= 2'h0;
        end else if (run_ff >= filt_last) begin
          lvl_ff <= s2_ff[i];
          run_ff <= 2'h0;
        end else begin
          run_ff <= run_ff + 2'h1;
        end
      end
      assign filt[i] = lvl_ff;
    end
  endgenerate

  // previous filtered levels for edge finding
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      fd_ff <= 2'h3;
    end else begin
      fd_ff <= filt;
    end
  end

  wire scl_rise = filt[1] & ~fd_ff[1];
  wire scl_fall = ~filt[1] & fd_ff[1];
  wire bus_start = filt[1] & fd_ff[1] & ~filt[0] & fd_ff[0];
  wire bus_stop = filt[1] & fd_ff[1] & filt[0] & ~fd_ff[0];
  wire is_hs_code = (sh_ff[7:3] == HS_CODE_PFX);
  wire is_own = (sh_ff[7:1] == own_addr);
  wire is_ara = (sh_ff[7:1] == ALERT_RESP_ADDR) & sh_ff[0] & alert_req;

  // -----------------------------------------------------------------
  // filtering mode
  // -----------------------------------------------------------------
  // set on master code, cleared by stop
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      hs_ff <= 1'b0;
    end else if (bus_stop) begin
      hs_ff <= 1'b0;
    end else if (state_ff == ST_ADDR && scl_fall && cnt_ff == LAST_BIT && is_hs_code) begin
      hs_ff <= 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // alert line
  // -----------------------------------------------------------------
  // held low for as long as the interrupt stands, won or lost
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      alert_oe_ff <= 1'b0;
    end else begin
      alert_oe_ff <= alert_req;
    end
  end

  // -----------------------------------------------------------------
  // byte framing
  // -----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      sh_ff <= 8'h00;
      tx_ff <= 8'h00;
      rw_ff <= 1'b0;
      ara_ff <= 1'b0;
      mack_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      rx_data_ff <= 8'h00;
      rx_valid_ff <= 1'b0;
      ara_won_ff <= 1'b0;
    end else begin
      rx_valid_ff <= 1'b0;
      ara_won_ff <= 1'b0;
      if (bus_stop) begin
        state_ff <= ST_IDLE;
        sda_oe_ff <= 1'b0;
      end else if (bus_start) begin
        // start or repeated start: same framing at either speed
        state_ff <= ST_ADDR;
        cnt_ff <= 4'h0;
        sda_oe_ff <= 1'b0;
      end else begin
        case (state_ff)
          ST_ADDR, ST_RX: begin
            if (scl_rise) begin
              sh_ff <= {sh_ff[6:0], filt[0]};
              cnt_ff <= cnt_ff + 4'h1;
            end else if (scl_fall && cnt_ff == LAST_BIT) begin
              cnt_ff <= 4'h0;
              if (state_ff == ST_RX) begin
                rx_data_ff <= sh_ff;
                rx_valid_ff <= 1'b1;
                sda_oe_ff <= 1'b1;
                state_ff <= ST_ACK;
              end else if (is_hs_code) begin
                state_ff <= ST_WAIT;
              end else if (is_own || is_ara) begin
                rw_ff <= sh_ff[0];
                ara_ff <= is_ara && !is_own;
                sda_oe_ff <= 1'b1;
                state_ff <= ST_ACK;
              end else begin
                state_ff <= ST_WAIT;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (rw_ff) begin
                tx_ff <= ara_ff ? {own_addr, 1'b0} : tx_byte;
                sda_oe_ff <= ara_ff ? ~own_addr[6] : ~tx_byte[7];
                state_ff <= ST_TX;
              end else begin
                sda_oe_ff <= 1'b0;
                state_ff <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_rise) begin
              cnt_ff <= cnt_ff + 4'h1;
              if (!sda_oe_ff && !filt[0]) begin
                // another sender pulled low while this end sent a one
                state_ff <= ST_WAIT;
              end
            end else if (scl_fall) begin
              if (cnt_ff == LAST_BIT) begin
                cnt_ff <= 4'h0;
                sda_oe_ff <= 1'b0;
                ara_won_ff <= ara_ff;
                state_ff <= ST_TXACK;
              end else begin
                tx_ff <= {tx_ff[6:0], 1'b0};
                sda_oe_ff <= ~tx_ff[6];
              end
            end
          end
          ST_TXACK: begin
            if (scl_rise) begin
              mack_ff <= ~filt[0];
            end else if (scl_fall) begin
              if (mack_ff && !ara_ff) begin
                tx_ff <= tx_byte;
                sda_oe_ff <= ~tx_byte[7];
                state_ff <= ST_TX;
              end else begin
                state_ff <= ST_WAIT;
              end
            end
          end
          default: begin
            // idle or waiting: sda released until the next start
            sda_oe_ff <= 1'b0;
          end
        endcase
      end
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign bus.s_sda_o = 1'b0;
  assign bus.s_alert_o = 1'b0;
  assign bus.s_sda_oe = sda_oe_ff;
  assign bus.s_alert_oe = alert_oe_ff;
  assign hs_mode = hs_ff;
  assign rx_data = rx_data_ff;
  assign rx_valid = rx_valid_ff;
  assign ara_won = ara_won_ff;
endmodule : ihsa_dev
`default_nettype wire

//--- core/ihsa_ctl.sv
// controller end: bus master issuing master code, reads, writes, alert response
`timescale 1ns/1ps
`default_nettype none
module ihsa_ctl import ihsa_pkg::*; (
  input wire logic clock, // system clock
  input wire logic reset_n, // synchronous reset
  ihsa_if.ctl bus, // two-wire bus
  input wire logic cmd_valid, // command request
  input wire ihsa_cmd_t cmd_kind, // what to do
  input wire logic [6:0] cmd_addr, // slave address, low 3 bits for master code
  input wire logic [7:0] cmd_data, // write byte
  input wire logic cmd_stop, // end with stop rather than hold, except master code, which always holds
  output logic cmd_ready, // command can be taken
  output logic done, // pulse: command finished
  output logic acked, // all bytes sent were acknowledged
  output logic [7:0] rd_data, // byte read
  output logic hs_active // bus clock at high speed
);
  typedef enum logic [4:0] {
    MS_IDLE = 5'b00001,
    MS_START = 5'b00010,
    MS_BYTE = 5'b00100,
    MS_HOLD = 5'b01000,
    MS_STOP = 5'b10000
  } ihsa_mst_t;

  ihsa_mst_t state_ff;
  ihsa_cmd_t kind_ff;
  logic [4:0] tcnt_ff;
  logic [1:0] qtr_ff;
  logic [3:0] bitn_ff;
  logic byten_ff;
  logic stop_ff;
  logic [7:0] data_ff;
  logic [7:0] tx_ff;
  logic [7:0] rx_ff;
  logic scl_oe_ff;
  logic sda_oe_ff;
  logic hs_ff;
  logic ready_ff;
  logic done_ff;
  logic acked_ff;
  logic [7:0] rd_ff;
  logic s1_ff;
  logic s2_ff;

  // -----------------------------------------------------------------
  // quarter-period divider
  // -----------------------------------------------------------------
  wire [4:0] qlast = hs_ff ? HS_QTR_LAST : FS_QTR_LAST;
  wire qend = (tcnt_ff == qlast);
  wire take = cmd_valid & ready_ff;
  wire mtx = !byten_ff || kind_ff == IHSA_CMD_WR;

  // two-flop synchroniser for sda
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
    end else begin
      s1_ff <= bus.sda;
      s2_ff <= s1_ff;
    end
  end

  // -----------------------------------------------------------------
  // sequencer
  // -----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_ff <= MS_IDLE;
      kind_ff <= IHSA_CMD_HS;
      tcnt_ff <= 5'h00;
      qtr_ff <= 2'h0;
      bitn_ff <= 4'h0;
      byten_ff <= 1'b0;
      stop_ff <= 1'b0;
      data_ff <= 8'h00;
      tx_ff <= 8'h00;
      rx_ff <= 8'h00;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      hs_ff <= 1'b0;
      ready_ff <= 1'b1;
      done_ff <= 1'b0;
      acked_ff <= 1'b0;
      rd_ff <= 8'h00;
    end else begin
      done_ff <= 1'b0;
      tcnt_ff <= (qend || state_ff == MS_IDLE) ? 5'h00 : tcnt_ff + 5'h01;
      if (qend) begin
        qtr_ff <= qtr_ff + 2'h1;
      end
      if (take) begin
        kind_ff <= cmd_kind;
        stop_ff <= cmd_stop;
        data_ff <= cmd_data;
        tcnt_ff <= 5'h00;
        qtr_ff <= 2'h0;
        byten_ff <= 1'b0;
        bitn_ff <= 4'h0;
        if (cmd_kind == IHSA_CMD_HS) begin
          tx_ff <= {HS_CODE_PFX, cmd_addr[2:0]};
        end else if (cmd_kind == IHSA_CMD_ARA) begin
          tx_ff <= {ALERT_RESP_ADDR, 1'b1};
        end else begin
          tx_ff <= {cmd_addr, cmd_kind == IHSA_CMD_RD};
        end
        if (cmd_kind != IHSA_CMD_STOP) begin
          state_ff <= MS_START;
          ready_ff <= 1'b0;
        end else if (state_ff == MS_HOLD) begin
          state_ff <= MS_STOP;
          ready_ff <= 1'b0;
        end else begin
          done_ff <= 1'b1;
        end
      end else if (qend) begin
        case (state_ff)
          MS_START: begin
            // scl is low on entry from hold, so releasing sda is safe
            if (qtr_ff == 2'h0) sda_oe_ff <= 1'b0;
            if (qtr_ff == 2'h1) scl_oe_ff <= 1'b0;
            if (qtr_ff == 2'h2) sda_oe_ff <= 1'b1;
            if (qtr_ff == 2'h3) state_ff <= MS_BYTE;
          end
          MS_BYTE: begin
            if (qtr_ff == 2'h0) scl_oe_ff <= 1'b1;
            if (qtr_ff == 2'h1) sda_oe_ff <= (bitn_ff != LAST_BIT) && mtx && !tx_ff[7];
            if (qtr_ff == 2'h2) scl_oe_ff <= 1'b0;
            if (qtr_ff == 2'h3) begin
              if (bitn_ff != LAST_BIT) begin
                rx_ff <= {rx_ff[6:0], s2_ff};
                tx_ff <= {tx_ff[6:0], 1'b0};
                bitn_ff <= bitn_ff + 4'h1;
              end else begin
                bitn_ff <= 4'h0;
                acked_ff <= byten_ff ? (acked_ff && (!mtx || !s2_ff)) : !s2_ff;
                if (!byten_ff && !s2_ff && kind_ff != IHSA_CMD_HS) begin
                  byten_ff <= 1'b1;
                  tx_ff <= data_ff;
                end else begin
                  done_ff <= 1'b1;
                  rd_ff <= rx_ff;
                  if (kind_ff == IHSA_CMD_HS) begin
                    hs_ff <= 1'b1;
                    state_ff <= MS_HOLD;
                  end else begin
                    state_ff <= stop_ff ? MS_STOP : MS_HOLD;
                  end
                end
              end
            end
          end
          MS_HOLD: begin
            // park with scl low until the next command
            scl_oe_ff <= 1'b1;
            ready_ff <= 1'b1;
          end
          MS_STOP: begin
            if (qtr_ff == 2'h0) scl_oe_ff <= 1'b1;
            if (qtr_ff == 2'h1) sda_oe_ff <= 1'b1;
            if (qtr_ff == 2'h2) scl_oe_ff <= 1'b0;
            if (qtr_ff == 2'h3) begin
              sda_oe_ff <= 1'b0;
              hs_ff <= 1'b0;
              ready_ff <= 1'b1;
              state_ff <= MS_IDLE;
            end
          end
          default: begin
            scl_oe_ff <= 1'b0;
          end
        endcase
      end
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign bus.m_scl_o = 1'b0;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_scl_oe = scl_oe_ff;
  assign bus.m_sda_oe = sda_oe_ff;
  assign cmd_ready = ready_ff;
  assign done = done_ff;
  assign acked = acked_ff;
  assign rd_data = rd_ff;
  assign hs_active = hs_ff;
endmodule : ihsa_ctl
`default_nettype wire

//--- bench/ihsa_sva.sv
// checker: wire-level properties of the two-wire link
`timescale 1ns/1ps
`default_nettype none
module ihsa_sva import ihsa_pkg::*; (
  input wire logic clock, // system clock
  input wire logic reset_n, // synchronous reset
  input wire logic scl, // wired clock line
  input wire logic sda, // wired data line
  input wire logic alert_n, // wired alert line
  input wire logic m_scl_oe, // controller pulls scl
  input wire logic m_sda_oe, // controller pulls sda
  input wire logic s_sda_oe // device pulls sda
);
  localparam int FS_MIN_HI = 15; // 600 ns high phase at 40 ns
  localparam int HS_MAX_HI = 8; // fast high phase is about 6
  logic scl_ff;
  logic sda_ff;
  logic first_ff;
  logic hs_ff;
  logic [3:0] cnt_ff;
  logic [7:0] byte_ff;
  logic [7:0] hi_ff;
  wire logic rise = scl & ~scl_ff;
  wire logic fall = ~scl & scl_ff;
  wire logic start = scl & scl_ff & sda_ff & ~sda;
  wire logic stop = scl & scl_ff & ~sda_ff & sda;
  wire logic ninth = rise & (cnt_ff == 4'h8) & first_ff;

  // -----------------------------------------------------------------
  // helper logic
  // -----------------------------------------------------------------
  // line history and length of the scl high phase
  always_ff @(posedge clock) begin
    scl_ff <= reset_n ? scl : 1'b1;
    sda_ff <= reset_n ? sda : 1'b1;
    hi_ff <= (reset_n && scl && hi_ff != 8'hff) ? hi_ff + 8'h01 : 8'h00;
  end

  // bit position inside a byte frame
  always_ff @(posedge clock) begin
    if (!reset_n || start || stop) cnt_ff <= 4'h0;
    else if (rise) cnt_ff <= cnt_ff + 4'h1;
    else if (fall && cnt_ff == 4'h9) cnt_ff <= 4'h0;
  end

  // first byte after a start, and high-speed state seen on the wire
  always_ff @(posedge clock) begin
    if (!reset_n || stop) first_ff <= 1'b0;
    else if (start) first_ff <= 1'b1;
    else if (fall && cnt_ff == 4'h9) first_ff <= 1'b0;
    if (!reset_n) byte_ff <= 8'h00;
    else if (rise && cnt_ff < 4'h8) byte_ff <= {byte_ff[6:0], sda};
    if (!reset_n || stop) hs_ff <= 1'b0;
    else if (ninth && byte_ff[7:3] == HS_CODE_PFX) hs_ff <= 1'b1;
  end

  // -----------------------------------------------------------------
  // properties
  // -----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence s_code_ninth;
    ninth && byte_ff[7:3] == HS_CODE_PFX;
  endsequence
  sequence s_ara_ninth;
    ninth && byte_ff == {ALERT_RESP_ADDR, 1'b1};
  endsequence
  property p_reset_idle;
    $rose(reset_n) |-> !m_scl_oe && !m_sda_oe && !s_sda_oe;
  endproperty
  property p_code_nack;
    s_code_ninth |-> sda;
  endproperty
  property p_code_fs;
    fall && !hs_ff && cnt_ff != 4'h0 |-> hi_ff >= FS_MIN_HI;
  endproperty
  property p_hs_fast;
    fall && hs_ff && cnt_ff inside {[4'h1:4'h8]} |-> hi_ff <= HS_MAX_HI;
  endproperty
  property p_ara_ack;
    s_ara_ninth and (!alert_n) |-> !sda;
  endproperty
  property p_ara_quiet;
    s_ara_ninth and alert_n |-> sda;
  endproperty
  property p_bit_stable;
    scl && scl_ff && cnt_ff >= 4'h2 |-> sda == sda_ff;
  endproperty
  property p_stop_quiet;
    stop |=> (!s_sda_oe) [*4];
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("line driven after reset");
  a_code_nack: assert property (p_code_nack) else $error("master code acknowledged");
  a_code_fs: assert property (p_code_fs) else $error("slow-phase clock high too short");
  a_hs_fast: assert property (p_hs_fast) else $error("fast phase clock too slow");
  a_ara_ack: assert property (p_ara_ack) else $error("alert response not acked");
  a_ara_quiet: assert property (p_ara_quiet) else $error("alert response acked idly");
  a_bit_stable: assert property (p_bit_stable) else $error("data moved while clock high");
  a_stop_quiet: assert property (p_stop_quiet) else $error("device drives after stop");
endmodule : ihsa_sva
`default_nettype wire

//--- bench/ihsa_tb.sv
// testbench: controller and device joined on one link
`timescale 1ns/1ps
`default_nettype none
module ihsa_tb import ihsa_pkg::*; ;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_stop = 1'b0;
  logic alert_req = 1'b0;
  ihsa_cmd_t cmd_kind = IHSA_CMD_WR;
  logic [6:0] cmd_addr = 7'h00;
  logic [6:0] own_addr = 7'h40;
  logic [7:0] cmd_data = 8'h00;
  logic [7:0] tx_byte = 8'h00;
  logic cmd_ready;
  logic done;
  logic acked;
  logic hs_mode;
  logic ara_won;
  logic [7:0] rd_data;
  logic [7:0] rx_data;
  logic [7:0] won_n = 8'h00;
  logic [7:0] rxv_n = 8'h00;
  logic hs_act;
  logic rx_vld;
  logic [7:0] w0;
  logic [7:0] d;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int seed = 32'h9264;

  ihsa_if ifc ();
  ihsa_ctl ihsa_ctl_inst (.clock(clock), .reset_n(reset_n), .bus(ifc.ctl),
    .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .cmd_stop(cmd_stop), .cmd_ready(cmd_ready), .done(done), .acked(acked),
    .rd_data(rd_data), .hs_active(hs_act));
  ihsa_dev ihsa_dev_inst (.clock(clock), .reset_n(reset_n), .bus(ifc.dev),
    .own_addr(own_addr), .alert_req(alert_req), .tx_byte(tx_byte), .hs_mode(hs_mode),
    .rx_data(rx_data), .rx_valid(rx_vld), .ara_won(ara_won));
  ihsa_sva ihsa_sva_inst (.clock(clock), .reset_n(reset_n), .scl(ifc.scl), .sda(ifc.sda),
    .alert_n(ifc.alert_n), .m_scl_oe(ifc.m_scl_oe), .m_sda_oe(ifc.m_sda_oe),
    .s_sda_oe(ifc.s_sda_oe));

  // -----------------------------------------------------------------
  // clock, hang limit, helpers
  // -----------------------------------------------------------------
  always #20 clock = ~clock;

  // cycle ceiling, tally of alert answers won and bytes received
  always @(posedge clock) begin
    cyc++;
    if (ara_won === 1'b1) won_n <= won_n + 8'h01;
    if (rx_vld === 1'b1) rxv_n <= rxv_n + 8'h01;
    if (cyc == 90000) begin
      bad_count++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic check(logic [7:0] seen, logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  function automatic logic pick(int w);
    return (w == 0) ? done : (w == 1) ? cmd_ready : hs_mode;
  endfunction : pick

  // bounded wait on done (0), cmd_ready (1) or hs_mode (2)
  task automatic wait_for(int w, logic lvl);
    int n;
    n = 0;
    while (pick(w) !== lvl && n < 4000) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n == 4000) begin
      bad_count++;
      finish_test();
    end
  endtask : wait_for

  // one command, held until taken, then waited out
  task automatic cmd(ihsa_cmd_t k, logic [6:0] a, logic [7:0] dv, logic s);
    wait_for(1, 1'b1);
    cmd_kind = k;
    cmd_addr = a;
    cmd_data = dv;
    cmd_stop = s;
    cmd_valid = 1'b1;
    @(posedge clock);
    #1;
    cmd_valid = 1'b0;
    if (k == IHSA_CMD_STOP) wait_for(1, 1'b1);
    else wait_for(0, 1'b1);
  endtask : cmd

  // -----------------------------------------------------------------
  // main sequence: odd rounds run at high speed
  // -----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clock);
    #1;
    reset_n = 1'b1;
    check(8'(hs_mode), 8'h00);
    for (int i = 0; i < 6; i++) begin
      own_addr = {1'b1, 6'($random(seed))};
      tx_byte = 8'($random(seed));
      d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
      if (i[0]) begin
        cmd(IHSA_CMD_HS, 7'($random(seed)), 8'h00, 1'b0);
        check(8'(acked), 8'h00);
        check(8'(hs_mode), 8'h01);
      end
      w0 = rxv_n;
      cmd(IHSA_CMD_WR, own_addr, d, 1'b0);
      check(8'(acked), 8'h01);
      check(rx_data, d);
      check(rxv_n - w0, 8'h01);
      cmd(IHSA_CMD_RD, own_addr, 8'h00, 1'b0);
      check(rd_data, tx_byte);
      cmd(IHSA_CMD_WR, own_addr ^ 7'h01, d, 1'b0);
      check(8'(acked), 8'h00);
      check(rxv_n - w0, 8'h01);
      check(8'(hs_mode), 8'(i[0]));
      check(8'(hs_act), 8'(i[0]));
      alert_req = 1'b1;
      w0 = won_n;
      cmd(IHSA_CMD_ARA, 7'h00, 8'h00, 1'b0);
      check(8'(acked), 8'h01);
      check(rd_data, {own_addr, 1'b0});
      check(won_n - w0, 8'h01);
      check(8'(ifc.alert_n), 8'h00);
      alert_req = 1'b0;
      cmd(IHSA_CMD_ARA, 7'h00, 8'h00, !i[0]);
      check(8'(acked), 8'h00);
      check(8'(ifc.alert_n), 8'h01);
      if (i[0]) cmd(IHSA_CMD_STOP, 7'h00, 8'h00, 1'b1);
      wait_for(2, 1'b0);
      check(8'(hs_mode), 8'h00);
      check(8'(hs_act), 8'h00);
      $display("test %0d done", i);
    end
    // enter high speed, then reset mid-run: must come back in fast/standard
    cmd(IHSA_CMD_HS, 7'h05, 8'h00, 1'b0);
    check(8'(hs_mode), 8'h01);
    reset_n = 1'b0;
    repeat (12) @(posedge clock);
    #1;
    reset_n = 1'b1;
    check(8'(hs_mode), 8'h00);
    check(8'(hs_act), 8'h00);
    cmd(IHSA_CMD_WR, own_addr, 8'h5a, 1'b1);
    check(8'(acked), 8'h01);
    check(rx_data, 8'h5a);
    $display("test reset done");
    finish_test();
  end
endmodule : ihsa_tb
`default_nettype wire
